// [hdl/elm_defs.vh]
// Constants of the error log manager: register map, source codes, codes.
// Assumes inclusion by bare name from the design file.
`ifndef ELM_DEFS_VH
`define ELM_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ELM_OFF_LOG_READ 12'h000
`define ELM_OFF_ENABLE 12'h004
`define ELM_OFF_CONTROL 12'h008
`define ELM_OFF_STATUS 12'h00C

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ELM_ENABLE_RESET 32'h0000_0000
`define ELM_CTRL_CLEAR_BIT 0
`define ELM_SRC_LSB 8
`define ELM_NO_ROUTE 8'hFF
`define ELM_ILLEGAL_PORT_READ 8'hFF

// ----------------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------------
`define ELM_SRC_MAINT 6'h1E
`define ELM_SRC_SHARED 6'h00
`define ELM_LANE_CODES {6'h26, 6'h27, 6'h1D, 6'h1C, 6'h3E, 6'h3D, 6'h39, \
  6'h3A, 6'h3B, 6'h3C, 6'h31, 6'h32, 6'h33, 6'h34, 6'h29, 6'h2A}

// ----------------------------------------------------------------------
// Error codes
// ----------------------------------------------------------------------
`define ELM_C_TW_LEN 8'h10
`define ELM_C_TW_ACK 8'h11
`define ELM_C_TW_ADDR_INC 8'h12
`define ELM_C_TW_START_STOP 8'h13
`define ELM_C_TW_CHECKSUM 8'h14
`define ELM_C_SCAN_WRITE 8'h20
`define ELM_C_MT_ROUTE 8'h30
`define ELM_C_MT_RD_SIZE 8'h31
`define ELM_C_MT_WR_SIZE 8'h32
`define ELM_C_MT_TTYPE 8'h33
`define ELM_C_MT_RD_PAYLOAD 8'h34
`define ELM_C_MT_WR_NOPAYLOAD 8'h35
`define ELM_C_MT_TOO_LONG 8'h36
`define ELM_C_CFG_MASK 8'h50
`define ELM_C_CFG_PORT 8'h53
`define ELM_C_CFG_FORCE_LOCAL 8'h54
`define ELM_C_CFG_ROUTE_READ 8'h55
`define ELM_C_CFG_MCAST_PORT 8'h56
`define ELM_C_LANE_SYNC 8'h60
`define ELM_C_LANE_ALIGN 8'h64

`endif

// [hdl/elm_error_log_manager.v]
// Error log manager: event inputs, arbiter, shared log FIFO, AXI4-Lite.
// Assumes event pulses are on aclk, one cycle each, from internal blocks.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "elm_defs.vh"

module elm_error_log_manager #(
  parameter LANES = 16,
  parameter DEPTH_LOG2 = 4
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Two-wire serial port events
  input wire tw_len_err,
  input wire tw_ack_err,
  input wire tw_addr_inc_err,
  input wire tw_start_stop_err,
  input wire tw_checksum_err,
  // Scan test port event
  input wire scan_write_err,
  // Maintenance handler events, bit i gives code 0x30+i
  input wire [6:0] mt_err,
  // Configuration events: mask, port, force-local, route read, mcast port
  input wire cfg_mask_err,
  input wire cfg_port_err,
  input wire cfg_force_local_err,
  input wire cfg_route_read_err,
  input wire cfg_mcast_port_err,
  // Lane events per lane: sync lost, alignment lost
  input wire [LANES-1:0] lane_sync_err,
  input wire [LANES-1:0] lane_align_err,
  // Report enables toward the sources
  output wire tw_report_en,
  output wire scan_report_en,
  output wire mt_report_en,
  output wire cfg_report_en,
  output wire [LANES-1:0] lane_report_en,
  // Log state
  output wire log_empty,
  output wire log_full
);

  // --------------------------------------------------------------------
  // Request vector
  // --------------------------------------------------------------------
  localparam NREQ = 24 + 2 * LANES; // Fixed sources plus lane pair each
  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam [6*16-1:0] LANE_CODES = `ELM_LANE_CODES;

  wire [NREQ-1:0] req_evt; // Event pulses, one per source and code
  wire [13:0] req_entry [0:NREQ-1]; // Source and code of each request

  // Pending flags wait for the arbiter
  reg [NREQ-1:0] pend_r;
  reg [NREQ-1:0] pend_nxt;
  reg [NREQ-1:0] grant;
  reg grant_any;
  integer gi;

  assign req_evt[0] = tw_len_err;
  assign req_entry[0] = {`ELM_SRC_SHARED, `ELM_C_TW_LEN};
  assign req_evt[1] = tw_ack_err;
  assign req_entry[1] = {`ELM_SRC_SHARED, `ELM_C_TW_ACK};
  assign req_evt[2] = tw_addr_inc_err;
  assign req_entry[2] = {`ELM_SRC_SHARED, `ELM_C_TW_ADDR_INC};
  assign req_evt[3] = tw_start_stop_err;
  assign req_entry[3] = {`ELM_SRC_SHARED, `ELM_C_TW_START_STOP};
  assign req_evt[4] = tw_checksum_err;
  assign req_entry[4] = {`ELM_SRC_SHARED, `ELM_C_TW_CHECKSUM};
  assign req_evt[5] = scan_write_err;
  assign req_entry[5] = {`ELM_SRC_SHARED, `ELM_C_SCAN_WRITE};
  assign req_evt[12:6] = mt_err;
  // Group nibble kept in each code
  genvar m;
  generate
    for (m = 0; m < 7; m = m + 1) begin : g_mt
      // Offset of this event from the route error code
      localparam integer MT_OFS = m;
      assign req_entry[6+m] = {`ELM_SRC_MAINT,
        `ELM_C_MT_ROUTE + MT_OFS[7:0]};
    end
  endgenerate
  assign req_evt[13] = cfg_mask_err;
  assign req_entry[13] = {`ELM_SRC_SHARED, `ELM_C_CFG_MASK};
  assign req_evt[14] = cfg_port_err;
  assign req_entry[14] = {`ELM_SRC_SHARED, `ELM_C_CFG_PORT};
  assign req_evt[15] = cfg_force_local_err;
  assign req_entry[15] = {`ELM_SRC_SHARED, `ELM_C_CFG_FORCE_LOCAL};
  assign req_evt[16] = cfg_route_read_err;
  assign req_entry[16] = {`ELM_SRC_SHARED, `ELM_C_CFG_ROUTE_READ};
  assign req_evt[17] = cfg_mcast_port_err;
  assign req_entry[17] = {`ELM_SRC_SHARED, `ELM_C_CFG_MCAST_PORT};
  // Spare fixed slots
  genvar s;
  generate
    for (s = 18; s < 24; s = s + 1) begin : g_spare
      assign req_evt[s] = 1'b0;
      assign req_entry[s] = 14'h0000;
    end
  endgenerate

  // Lane codes: sync by lane in quad, alignment 0x64
  // Lane source codes from fixed table
  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : g_lane
      // Position of this lane inside its quad
      localparam integer QUAD_LANE = l % 4;
      assign req_evt[24+2*l] = lane_sync_err[l];
      assign req_entry[24+2*l] = {LANE_CODES[6*(l%16) +: 6],
        `ELM_C_LANE_SYNC + QUAD_LANE[7:0]};
      assign req_evt[25+2*l] = lane_align_err[l];
      assign req_entry[25+2*l] = {LANE_CODES[6*(l%16) +: 6],
        `ELM_C_LANE_ALIGN};
    end
  endgenerate

  // --------------------------------------------------------------------
  // Arbiter: lowest pending index wins, one entry per cycle
  // --------------------------------------------------------------------
  // Fixed priority grant of one source
  always @* begin
    grant = {NREQ{1'b0}};
    grant_any = 1'b0;
    for (gi = 0; gi < NREQ; gi = gi + 1) begin
      if (pend_r[gi] && !grant_any) begin
        grant[gi] = 1'b1;
        grant_any = 1'b1;
      end
    end
  end

  // Pending next: a new event wins over its own grant
  always @* begin
    pend_nxt = (pend_r & ~grant) | req_evt;
  end

  // Pending register
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= {NREQ{1'b0}};
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Granted entry mux
  reg [13:0] win_entry;
  integer wi;
  always @* begin
    win_entry = 14'h0000;
    for (wi = 0; wi < NREQ; wi = wi + 1) begin
      if (grant[wi]) begin
        win_entry = req_entry[wi];
      end
    end
  end

  // --------------------------------------------------------------------
  // Log FIFO
  // --------------------------------------------------------------------
  reg [13:0] log_mem [0:DEPTH-1]; // Log storage
  reg [DEPTH_LOG2:0] wr_ptr_r; // Write pointer with wrap bit
  reg [DEPTH_LOG2:0] rd_ptr_r; // Read pointer with wrap bit
  wire log_clear; // Software clear strobe
  wire log_pop; // Read of the log register
  wire push;

  // Equal pointers mean empty; wrap bits differing with equal index, full
  assign log_empty = (wr_ptr_r == rd_ptr_r);
  assign log_full = (wr_ptr_r[DEPTH_LOG2] != rd_ptr_r[DEPTH_LOG2]) &&
    (wr_ptr_r[DEPTH_LOG2-1:0] == rd_ptr_r[DEPTH_LOG2-1:0]);
  // A clear in the same cycle wins, and the granted entry is lost
  // Logged regardless of enables
  assign push = grant_any && !log_full && !log_clear;

  // Store 6-bit source and 8-bit code
  always @(posedge aclk) begin
    if (push) begin
      log_mem[wr_ptr_r[DEPTH_LOG2-1:0]] <= win_entry;
    end
  end

  // Pointers
  // Clear empties the log
  always @(posedge aclk) begin
    if (!aresetn || log_clear) begin
      wr_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
      rd_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      // A read of an empty log leaves the read pointer where it is
      if (log_pop && !log_empty) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [31:0] enable_r; // Report enables
  assign tw_report_en = enable_r[0];
  assign scan_report_en = enable_r[1];
  assign mt_report_en = enable_r[2];
  assign cfg_report_en = enable_r[3];
  assign lane_report_en = enable_r[4 +: LANES];

  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  reg aw_held_r; // Write address taken
  reg w_held_r; // Write data taken
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire wr_go;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r;
  // Control write with clear bit set
  assign log_clear = wr_go && (awaddr_r == `ELM_OFF_CONTROL) &&
    wstrb_r[0] && wdata_r[`ELM_CTRL_CLEAR_BIT];

  // Capture address and data, then respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      enable_r <= `ELM_ENABLE_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Address decode
        if (awaddr_r == `ELM_OFF_ENABLE) begin
          s_axi_bresp <= 2'b00;
          if (wstrb_r[0]) enable_r[7:0] <= wdata_r[7:0];
          if (wstrb_r[1]) enable_r[15:8] <= wdata_r[15:8];
          if (wstrb_r[2]) enable_r[23:16] <= wdata_r[23:16];
          if (wstrb_r[3]) enable_r[31:24] <= wdata_r[31:24];
        end else if (awaddr_r == `ELM_OFF_CONTROL ||
                     awaddr_r == `ELM_OFF_LOG_READ ||
                     awaddr_r == `ELM_OFF_STATUS) begin
          s_axi_bresp <= 2'b00;
        end else begin
          // Unmapped address answers with a slave error
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  // Oldest entry, read straight from the log storage
  wire [13:0] head_entry;
  assign head_entry = log_mem[rd_ptr_r[DEPTH_LOG2-1:0]];
  // One read under way at a time
  assign s_axi_arready = !s_axi_rvalid;
  // Reading the log register takes the oldest entry
  assign log_pop = s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr == `ELM_OFF_LOG_READ);

  // Read data, one cycle after the address
  // Data stands until the master takes it with rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == `ELM_OFF_LOG_READ) begin
        s_axi_rdata <= log_empty ? 32'h0000_0000 :
          {18'h0_0000, head_entry};
      end else if (s_axi_araddr == `ELM_OFF_ENABLE) begin
        s_axi_rdata <= enable_r;
      end else if (s_axi_araddr == `ELM_OFF_CONTROL) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == `ELM_OFF_STATUS) begin
        s_axi_rdata <= {30'h0000_0000, log_full, log_empty};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // elm_error_log_manager

// [tb/elm_checker.sv]
// Checker for the error log manager: bus handshakes and log state.
// Assumes it is bound to elm_error_log_manager and sees only its ports.
`timescale 1ns/1ps
module elm_chk #(
  parameter LANES = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tw_len_err,
  input wire tw_report_en,
  input wire [LANES-1:0] lane_report_en,
  input wire log_empty,
  input wire log_full
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_en_a: assert property ($rose(aresetn) |-> !tw_report_en
    && lane_report_en == 0) else $error("enables set after reset");
  ev_logged_a: assert property (log_empty && tw_len_err
    |-> ##[1:3] !log_empty) else $error("event not logged");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  empty_zero_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 12'h000 && log_empty |=> s_axi_rdata == 32'h0)
    else $error("empty log read not zero");
  full_keep_a: assert property (log_full && !s_axi_arvalid
    && !s_axi_awvalid |=> log_full) else $error("full log lost entries");
  clr_empty_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 12'h008
    && s_axi_wdata[0] |-> ##[1:2] log_empty) else $error("clear failed");
  full_cov: cover property (log_full);
  pop_cov: cover property (s_axi_arvalid && s_axi_arready && !log_empty);
  ev_cov: cover property (log_empty && tw_len_err);
endmodule // elm_chk

bind elm_error_log_manager elm_chk #(.LANES(LANES)) elm_chk_inst (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .tw_len_err, .tw_report_en, .lane_report_en, .log_empty, .log_full);

// [tb/elm_src_model.sv]
// Model of the internal error sources: one-cycle event pulses.
// Assumes the bench names one event per cycle by its index.
`timescale 1ns/1ps
module elm_src_model (
  input wire aclk,
  input wire fire,
  input wire [5:0] fire_id,
  output wire [4:0] tw_ev,
  output wire scan_ev,
  output wire [6:0] mt_ev,
  output wire [4:0] cfg_ev,
  output wire [15:0] sync_ev,
  output wire [15:0] align_ev
);
  reg [49:0] ev_r = 50'h0; // One bit per event line
  always @(posedge aclk) begin
    ev_r <= fire ? (50'h1 << fire_id) : 50'h0;
  end
  assign {align_ev, sync_ev, cfg_ev, mt_ev, scan_ev, tw_ev} = ev_r;
endmodule // elm_src_model

// [tb/tb_top.sv]
// Testbench for the error log manager over AXI4-Lite.
// Assumes the source model drives all event inputs.
`timescale 1ns/1ps
module tb_top;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
  reg [11:0] awaddr, araddr;
  reg [31:0] wdata;
  reg [5:0] fire_id;
  wire awready, wready, bvalid, arready, rvalid, scan_ev, log_empty, log_full;
  wire tw_en, scan_en, mt_en, cfg_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] tw_ev, cfg_ev;
  wire [6:0] mt_ev;
  wire [15:0] sync_ev, align_ev, lane_en;
  int n_mismatch, cmp_count, cyc, i;
  // Lane source codes, lane 0 in the low bits
  localparam [95:0] LSRC = {6'h26, 6'h27, 6'h1D, 6'h1C, 6'h3E, 6'h3D,
    6'h39, 6'h3A, 6'h3B, 6'h3C, 6'h31, 6'h32, 6'h33, 6'h34, 6'h29, 6'h2A};
  localparam [39:0] CFGC = {8'h56, 8'h55, 8'h54, 8'h53, 8'h50};

  elm_src_model elm_src_model_inst (.aclk(aclk), .fire(fire),
    .fire_id(fire_id), .tw_ev(tw_ev), .scan_ev(scan_ev), .mt_ev(mt_ev),
    .cfg_ev(cfg_ev), .sync_ev(sync_ev), .align_ev(align_ev));
  elm_error_log_manager elm_error_log_manager_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tw_len_err(tw_ev[0]), .tw_ack_err(tw_ev[1]),
    .tw_addr_inc_err(tw_ev[2]), .tw_start_stop_err(tw_ev[3]),
    .tw_checksum_err(tw_ev[4]), .scan_write_err(scan_ev), .mt_err(mt_ev),
    .cfg_mask_err(cfg_ev[0]), .cfg_port_err(cfg_ev[1]),
    .cfg_force_local_err(cfg_ev[2]), .cfg_route_read_err(cfg_ev[3]),
    .cfg_mcast_port_err(cfg_ev[4]), .lane_sync_err(sync_ev),
    .lane_align_err(align_ev), .tw_report_en(tw_en),
    .scan_report_en(scan_en), .mt_report_en(mt_en), .cfg_report_en(cfg_en),
    .lane_report_en(lane_en), .log_empty(log_empty), .log_full(log_full));

  // Expected log entry for event index id
  function [31:0] exp_e(input int id);
    if (id < 5) exp_e = 32'h0010 + id;
    else if (id == 5) exp_e = 32'h0020;
    else if (id < 13) exp_e = {18'h0, 6'h1E, 8'h30} + id - 6;
    else if (id < 18) exp_e = {24'h0, CFGC[(id-13)*8 +: 8]};
    else if (id < 34)
      exp_e = {18'h0, LSRC[(id-18)*6 +: 6], 8'h60} + (id - 18) % 4;
    else exp_e = {18'h0, LSRC[(id-34)*6 +: 6], 8'h64};
  endfunction

  task summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    reg a1, w1, ka, kw;
    reg [1:0] r;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    ka = 0; kw = 0;
    while (!(ka && kw)) begin
      @(negedge aclk);
      a1 = !ka && awready; w1 = !kw && wready;
      @(posedge aclk);
      if (a1) awvalid <= 0;
      if (w1) wvalid <= 0;
      ka = ka | a1; kw = kw | w1;
    end
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    @(posedge aclk) bready <= 0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    reg [31:0] d;
    reg [1:0] r;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk) arvalid <= 0;
    do @(negedge aclk); while (!rvalid);
    d = rdata; r = rresp;
    @(posedge aclk) rready <= 0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // One event, then wait until the log is not empty
  task fire_one(input int id);
    @(posedge aclk);
    fire <= 1; fire_id <= id;
    @(posedge aclk) fire <= 0;
    do @(negedge aclk); while (log_empty);
  endtask

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // Cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = 0;
    {awaddr, araddr, wdata, fire_id, n_mismatch, cmp_count, cyc} = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(12'h004, 32'h0, 2'b00);
    rd(12'h00C, 32'h1, 2'b00);
    rd(12'h000, 32'h0, 2'b00);
    wr(12'h004, 32'h000F_FFFF, 2'b00);
    chk({lane_en, cfg_en, mt_en, scan_en, tw_en}, 32'h000F_FFFF);
    rd(12'h004, 32'h000F_FFFF, 2'b00);
    wr(12'h004, 32'h0, 2'b00);
    for (i = 0; i < 50; i++) begin
      fire_one(i);
      rd(12'h000, exp_e(i), 2'b00);
    end
    @(posedge aclk);
    for (i = 0; i < 17; i++) begin
      fire <= 1; fire_id <= 18 + i;
      @(posedge aclk);
    end
    fire <= 0;
    repeat (4) @(posedge aclk);
    rd(12'h00C, 32'h2, 2'b00);
    chk({30'h0, log_full, log_empty}, 32'h2);
    for (i = 0; i < 16; i++) rd(12'h000, exp_e(18 + i), 2'b00);
    rd(12'h00C, 32'h1, 2'b00);
    for (i = 0; i < 3; i++) fire_one(i);
    wr(12'h008, 32'h1, 2'b00);
    rd(12'h00C, 32'h1, 2'b00);
    rd(12'h000, 32'h0, 2'b00);
    wr(12'h010, 32'h5, 2'b10);
    rd(12'h010, 32'h0, 2'b10);
    summarize;
  end
endmodule // tb_top
